/* File: smfs_defines.vh */
// constants shared by the status monitor frame source
`ifndef SMFS_DEFINES_VH
`define SMFS_DEFINES_VH

// ----------------------------------------------------------------
// system clock
// ----------------------------------------------------------------
`define SMFS_CLK_PERIOD_NS  10
`define SMFS_CLK_KHZ        100000

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SMFS_ADDR_W         4
`define SMFS_STAT_W         8
`define SMFS_FRAME_W        12
`define SMFS_LAST_ADDR      4
`define SMFS_BIT_CNT_W      4

// ----------------------------------------------------------------
// one-shot stretch time
// ----------------------------------------------------------------
`define SMFS_ONE_SHOT_NS    20000
`define SMFS_ONE_SHOT_W     12

// ----------------------------------------------------------------
// monitor rate selection and rates
// ----------------------------------------------------------------
`define SMFS_RATE_OFF       2'h0
`define SMFS_RATE_SLOW      2'h1
`define SMFS_RATE_MID       2'h2
`define SMFS_RATE_FAST      2'h3
`define SMFS_RATE_SLOW_KHZ  100
`define SMFS_RATE_MID_KHZ   1140
`define SMFS_RATE_FAST_KHZ  8000
`define SMFS_DIV_W          10

// ----------------------------------------------------------------
// fifo defaults
// ----------------------------------------------------------------
`define SMFS_FIFO_DEPTH     32
`define SMFS_FIFO_AW        5

`endif

/* File: smfs_fifo.v */
// synchronous fifo holding assembled status frames
`timescale 1ns/1ps

module smfs_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  reg [AW:0]      used_q;

  // honest flags from the occupancy count
  assign in_ready  = (used_q != DEPTH[AW:0]);
  assign out_valid = (used_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q[AW-1:0]];

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // storage write, no reset needed on the array
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // pointers wrap at the depth so non-power-of-two depths work
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q   <= {(AW+1){1'b0}};
      rd_q   <= {(AW+1){1'b0}};
      used_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}}
                                             : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW:0] - 1'b1) ? {(AW+1){1'b0}}
                                             : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        used_q <= used_q + 1'b1;
      end else if (pop & ~push) begin
        used_q <= used_q - 1'b1;
      end
    end
  end

endmodule // smfs_fifo

/* File: smfs_top.v */
// status monitor frame source: builds and serialises status frames
// Operation
// - frame0 D7 correlation, D6 sync held
// - frame0 D4 fast mode, D3 hopping
// - frame0 D2 tx running, D1 idle
// - frame0 D0 sticky fault, D5 zero
// - frame1 D7..D5 rx, ack, error pulses
// - each pulse stretched to 20 us
// - frame1 D4 high during wakeup reception
// - frame1 D3..D1 last tx code, D0 zero
// - code bit 2 means relay reached
// - code low bits give destination outcome
// - frame2 D7 rx full, D6 rx nonempty
// - frame2 D5 tx full, D3 overrun, mode7
// - frame2 D4 high in mode 7
// - frame2 D2 tx nonempty, D1 D0 zero
// - frame3 D7 host out, D5 host in
// - frame3 D6 radio receive enabled
// - frame3 D4..D0 channel number 0..23
// - 12 bit frame, address then data, MSB first
// - frames 0 to 4, repeated forever
// - 2 bit rate, 00 off, clock halved
`timescale 1ns/1ps
`include "smfs_defines.vh"

module smfs_top #(
  parameter FIFO_DEPTH = `SMFS_FIFO_DEPTH,
  parameter FIFO_AW    = `SMFS_FIFO_AW
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       reset_n,
  // configuration
  input  wire [1:0] monitor_rate_setting,
  // link and sequencing status
  input  wire       correlation_seen,
  input  wire       frame_sync_found,
  input  wire       fast_link_mode_active,
  input  wire       channel_hop_in_progress,
  input  wire       tx_command_running,
  input  wire       radio_sequencer_idle,
  input  wire       system_fault_flag,
  // reception events, one cycle each, plus the wakeup level shown raw
  input  wire       rx_ok_pulse,
  input  wire       own_ack_ok_pulse,
  input  wire       rx_error_pulse,
  input  wire       wakeup_packet_seen,
  // transmit outcome, taken on its strobe
  input  wire       tx_outcome_valid,
  input  wire [2:0] tx_outcome_code,
  // buffer state
  input  wire       receive_store_full,
  input  wire       receive_store_nonempty,
  input  wire       send_store_full,
  input  wire       mode_seven_active,
  input  wire       send_store_overrun,
  input  wire       send_store_nonempty,
  // port enables, channel and top-level state
  input  wire       host_output_allowed,
  input  wire       radio_rx_allowed,
  input  wire       host_input_allowed,
  input  wire [4:0] current_channel_number,
  input  wire [4:0] top_level_state,
  // monitor pins
  output reg        status_data,
  output reg        status_clock,
  output reg        status_load
);

  // ----------------------------------------------------------------
  // derived timing
  // ----------------------------------------------------------------
  // least time, so round up; full-width results cut to size on purpose
  localparam SHOT_FULL =
    (`SMFS_ONE_SHOT_NS + `SMFS_CLK_PERIOD_NS - 1) / `SMFS_CLK_PERIOD_NS;
  localparam [`SMFS_ONE_SHOT_W-1:0] SHOT_CYC =
    SHOT_FULL[`SMFS_ONE_SHOT_W-1:0];
  // half-period ticks of the monitor clock, dividers rounded down
  localparam DIV_SLOW_FULL = `SMFS_CLK_KHZ / `SMFS_RATE_SLOW_KHZ;
  localparam [`SMFS_DIV_W-1:0] DIV_SLOW = DIV_SLOW_FULL[`SMFS_DIV_W-1:0];
  localparam DIV_MID_FULL = `SMFS_CLK_KHZ / `SMFS_RATE_MID_KHZ;
  localparam [`SMFS_DIV_W-1:0] DIV_MID = DIV_MID_FULL[`SMFS_DIV_W-1:0];
  localparam DIV_FAST_FULL = `SMFS_CLK_KHZ / `SMFS_RATE_FAST_KHZ;
  localparam [`SMFS_DIV_W-1:0] DIV_FAST = DIV_FAST_FULL[`SMFS_DIV_W-1:0];

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_SHIFT = 2'h1;
  localparam [1:0] ST_LOAD  = 2'h2;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg  rst_meta_q;
  reg  rst_n_q;

  // assert at once, release two edges later
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // held status bits
  // ----------------------------------------------------------------
  reg       sync_held_q;
  reg       fault_seen_q;
  reg [2:0] tx_code_q;

  // sync set wins over loss of correlation in the same cycle
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync_held_q  <= 1'b0;
      fault_seen_q <= 1'b0;
      tx_code_q    <= 3'h0;
    end else begin
      if (frame_sync_found) begin
        sync_held_q <= 1'b1;
      end else if (!correlation_seen) begin
        sync_held_q <= 1'b0;
      end
      if (system_fault_flag) begin
        fault_seen_q <= 1'b1;
      end
      if (tx_outcome_valid) begin
        tx_code_q <= tx_outcome_code;
      end
    end
  end

  // ----------------------------------------------------------------
  // one-shot stretchers
  // ----------------------------------------------------------------
  wire [2:0] shot_in;
  wire [2:0] shot_out;

  assign shot_in = {rx_ok_pulse, own_ack_ok_pulse, rx_error_pulse};

  // a fresh event restarts its window rather than being lost
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_shot
      reg [`SMFS_ONE_SHOT_W-1:0] cnt_q;
      always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          cnt_q <= {`SMFS_ONE_SHOT_W{1'b0}};
        end else if (shot_in[g]) begin
          cnt_q <= SHOT_CYC;
        end else if (cnt_q != {`SMFS_ONE_SHOT_W{1'b0}}) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
      assign shot_out[g] = (cnt_q != {`SMFS_ONE_SHOT_W{1'b0}});
    end
  endgenerate

  // ----------------------------------------------------------------
  // frame assembly
  // ----------------------------------------------------------------
  reg [`SMFS_STAT_W-1:0] stat_d;
  reg [`SMFS_ADDR_W-1:0] addr_q;

  // choose the status byte for the current frame address
  always @* begin
    case (addr_q)
      4'h0: begin
        stat_d = {correlation_seen,
                  sync_held_q,
                  1'b0,
                  fast_link_mode_active,
                  channel_hop_in_progress,
                  tx_command_running,
                  radio_sequencer_idle,
                  fault_seen_q};
      end
      4'h1: begin
        // code bit 2 relay reached, bits 1..0 destination outcome
        stat_d = {shot_out,
                  wakeup_packet_seen,
                  tx_code_q,
                  1'b0};
      end
      4'h2: begin
        stat_d = {receive_store_full,
                  receive_store_nonempty,
                  send_store_full & mode_seven_active,
                  mode_seven_active,
                  send_store_overrun & mode_seven_active,
                  send_store_nonempty,
                  2'h0};
      end
      4'h3: begin
        stat_d = {host_output_allowed,
                  radio_rx_allowed,
                  host_input_allowed,
                  current_channel_number};
      end
      4'h4: begin
        // reserved state field, shown raw for debug only
        stat_d = {3'h0, top_level_state};
      end
      default: begin
        stat_d = {`SMFS_STAT_W{1'b0}};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // frame fifo
  // ----------------------------------------------------------------
  // deep fifo trades freshness for slack: a stalled drain leaves
  // frames up to one fifo depth old, so keep the depth small when
  // live status matters more than decoupling
  wire                    fifo_in_ready;
  wire                    fifo_out_valid;
  wire                    fifo_out_ready;
  wire [`SMFS_FRAME_W-1:0] fifo_out_data;

  smfs_fifo #(
    .WIDTH (`SMFS_FRAME_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_n_q),
    .in_valid  (rst_n_q),
    .in_ready  (fifo_in_ready),
    .in_data   ({addr_q, stat_d}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // next address only advances once the fifo took the frame
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      addr_q <= {`SMFS_ADDR_W{1'b0}};
    end else if (fifo_in_ready) begin
      if (addr_q == `SMFS_LAST_ADDR) begin
        addr_q <= {`SMFS_ADDR_W{1'b0}};
      end else begin
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // monitor rate divider
  // ----------------------------------------------------------------
  reg [`SMFS_DIV_W-1:0] div_sel;
  reg [`SMFS_DIV_W-1:0] div_q;
  wire                  rate_on;
  wire                  tick;

  // rate setting picks the half-period length
  always @* begin
    case (monitor_rate_setting)
      `SMFS_RATE_SLOW: div_sel = DIV_SLOW;
      `SMFS_RATE_MID:  div_sel = DIV_MID;
      `SMFS_RATE_FAST: div_sel = DIV_FAST;
      default:         div_sel = {`SMFS_DIV_W{1'b0}};
    endcase
  end

  assign rate_on = (monitor_rate_setting != `SMFS_RATE_OFF);
  assign tick    = rate_on && (div_q == div_sel - 1'b1);

  // off setting holds the divider so no power goes into toggling
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= {`SMFS_DIV_W{1'b0}};
    end else if (!rate_on || tick) begin
      div_q <= {`SMFS_DIV_W{1'b0}};
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serialiser
  // ----------------------------------------------------------------
  reg [1:0]                 state_q;
  reg                       phase_q;
  reg [`SMFS_BIT_CNT_W-1:0] bit_q;
  reg [`SMFS_FRAME_W-1:0]   shift_q;

  // a frame is taken only between frames, with the clock running
  assign fifo_out_ready = rate_on && (state_q == ST_IDLE);

  // two ticks per bit: clock low with new data, then clock high
  always @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q      <= ST_IDLE;
      phase_q      <= 1'b0;
      bit_q        <= {`SMFS_BIT_CNT_W{1'b0}};
      shift_q      <= {`SMFS_FRAME_W{1'b0}};
      status_data  <= 1'b0;
      status_clock <= 1'b0;
      status_load  <= 1'b0;
    end else if (!rate_on) begin
      // switching off mid-frame abandons it with pins quiet
      state_q      <= ST_IDLE;
      phase_q      <= 1'b0;
      status_data  <= 1'b0;
      status_clock <= 1'b0;
      status_load  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (fifo_out_valid) begin
            shift_q <= fifo_out_data;
            bit_q   <= {`SMFS_BIT_CNT_W{1'b0}};
            phase_q <= 1'b0;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick && !phase_q) begin
            status_clock <= 1'b0;
            status_data  <= shift_q[`SMFS_FRAME_W-1];
            phase_q      <= 1'b1;
          end else if (tick) begin
            status_clock <= 1'b1;
            phase_q      <= 1'b0;
            shift_q <= {shift_q[`SMFS_FRAME_W-2:0], 1'b0};
            if (bit_q == `SMFS_FRAME_W - 1) begin
              state_q <= ST_LOAD;
            end else begin
              bit_q <= bit_q + 1'b1;
            end
          end
        end
        ST_LOAD: begin
          // load rises after the last clock rise, one half period
          if (tick && !phase_q) begin
            status_clock <= 1'b0;
            status_load  <= 1'b1;
            phase_q      <= 1'b1;
          end else if (tick) begin
            status_load <= 1'b0;
            phase_q     <= 1'b0;
            state_q     <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // smfs_top

/* File: smfs_top_chk.sv */
// assertion checker for the status monitor frame source pins
`timescale 1ns/1ps

module smfs_top_chk (
  // clock and reset
  input wire       sys_clk,
  input wire       reset_n,
  // configuration
  input wire [1:0] monitor_rate_setting,
  // monitor pins
  input wire       status_data,
  input wire       status_clock,
  input wire       status_load
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic [9:0] hi_len_q;
  logic [3:0] rise_q;

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // high phase length and clock rises per frame; an abort clears the
  // rise count because the abandoned frame never gets its load
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_len_q <= 10'h000;
      rise_q   <= 4'h0;
    end else begin
      hi_len_q <= status_clock ? hi_len_q + 10'h001 : 10'h000;
      if (status_load || monitor_rate_setting == 2'h0)
        rise_q <= 4'h0;
      else if ($rose(status_clock))
        rise_q <= rise_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_off_pins_low: assert property (
    monitor_rate_setting == 2'h0 && $past(monitor_rate_setting) == 2'h0
    |-> !status_clock && !status_load)
    else $error("monitor pins active while rate is off");
  chk_slow_half_period: assert property (
    $fell(status_clock) && $past(monitor_rate_setting) == 2'h1
    |-> hi_len_q == 10'h3E8)
    else $error("slow rate half period wrong");
  chk_mid_half_period: assert property (
    $fell(status_clock) && $past(monitor_rate_setting) == 2'h2
    |-> hi_len_q == 10'h057)
    else $error("mid rate half period wrong");
  chk_fast_half_period: assert property (
    $fell(status_clock) && $past(monitor_rate_setting) == 2'h3
    |-> hi_len_q == 10'h00C)
    else $error("fast rate half period wrong");
  chk_load_width: assert property (
    disable iff (!reset_n || monitor_rate_setting != 2'h3)
    $rose(status_load)
    |-> status_load [*8] ##1 status_load [*4] ##1 !status_load)
    else $error("load strobe width wrong");
  chk_twelve_bits: assert property (
    $rose(status_load) |-> rise_q == 4'hC)
    else $error("load not preceded by twelve clock rises");
  chk_data_steady: assert property (
    status_clock && $past(status_clock) |-> $stable(status_data))
    else $error("data moved while clock high");
  chk_load_clock_low: assert property (
    status_load |-> !status_clock)
    else $error("clock high during load");
  chk_reset_quiet: assert property (
    $rose(reset_n) |-> (!status_clock && !status_load) [*2])
    else $error("pins active just after reset");
endmodule // smfs_top_chk

bind smfs_top smfs_top_chk i_chk (
  .sys_clk              (sys_clk),
  .reset_n              (reset_n),
  .monitor_rate_setting (monitor_rate_setting),
  .status_data          (status_data),
  .status_clock         (status_clock),
  .status_load          (status_load)
);

/* File: smfs_capture_model.sv */
// behavioural capture board for the status monitor pins
`timescale 1ns/1ps

module smfs_capture_model (
  // monitor pins
  input  wire         status_data,
  input  wire         status_clock,
  input  wire         status_load,
  // captured frame
  output logic [3:0]  got_addr,
  output logic [7:0]  got_data,
  output logic [4:0]  got_bits,
  output logic [15:0] frame_count
);
  logic [11:0] shift_q = 12'h000;
  logic [4:0]  bits_q  = 5'h00;

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // no reset pin here, so an aborted frame shows up as a long count
  initial begin
    got_addr    = 4'h0;
    got_data    = 8'h00;
    got_bits    = 5'h00;
    frame_count = 16'h0000;
  end

  // frame 4 is handed on as is and never judged
  always @(posedge status_clock or posedge status_load) begin
    if (status_load) begin
      got_addr    <= shift_q[11:8];
      got_data    <= shift_q[7:0];
      got_bits    <= bits_q;
      bits_q      <= 5'h00;
      frame_count <= frame_count + 16'h0001;
    end else begin
      shift_q <= {shift_q[10:0], status_data};
      bits_q  <= bits_q + 5'h01;
    end
  end
endmodule // smfs_capture_model

/* File: smfs_top_test.sv */
// self-checking bench for the status monitor frame source
`timescale 1ns/1ps

module smfs_top_test;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  rate = 2'h3;
  logic [6:0]  f0 = 7'h00;
  logic [3:0]  ev = 4'h0;
  logic [5:0]  st2 = 6'h00;
  logic [2:0]  st3 = 3'h0;
  logic [2:0]  tc = 3'h0;
  logic        tv = 1'b0;
  logic [4:0]  ch = 5'h00;
  logic [4:0]  tls = 5'h00;
  wire         status_data, status_clock, status_load;
  wire  [3:0]  got_addr;
  wire  [7:0]  got_data;
  wire  [4:0]  got_bits;
  wire  [15:0] frame_count;
  int          n_fail = 0;
  int          checks = 0;

  // ----------------------------------------------------------------
  // design and capture board
  // ----------------------------------------------------------------
  // a shallow fifo keeps captured frames close to the inputs
  smfs_top #(.FIFO_DEPTH(4), .FIFO_AW(2)) i_dut (
    .sys_clk, .reset_n, .monitor_rate_setting(rate),
    .correlation_seen(f0[6]), .frame_sync_found(f0[5]),
    .fast_link_mode_active(f0[4]), .channel_hop_in_progress(f0[3]),
    .tx_command_running(f0[2]), .radio_sequencer_idle(f0[1]),
    .system_fault_flag(f0[0]), .wakeup_packet_seen(ev[3]),
    .rx_ok_pulse(ev[2]), .own_ack_ok_pulse(ev[1]), .rx_error_pulse(ev[0]),
    .tx_outcome_valid(tv), .tx_outcome_code(tc),
    .receive_store_full(st2[5]), .receive_store_nonempty(st2[4]),
    .send_store_full(st2[3]), .mode_seven_active(st2[2]),
    .send_store_overrun(st2[1]), .send_store_nonempty(st2[0]),
    .host_output_allowed(st3[2]), .radio_rx_allowed(st3[1]),
    .host_input_allowed(st3[0]), .current_channel_number(ch),
    .top_level_state(tls), .status_data, .status_clock, .status_load);
  smfs_capture_model i_cap (.status_data, .status_clock, .status_load,
    .got_addr, .got_data, .got_bits, .frame_count);

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic next_frame;
    int i;
    logic [15:0] c;
    c = frame_count;
    for (i = 0; i < 3000 && frame_count == c; i++) step(1);
    chk(frame_count != c, 1'b1);
  endtask
  // six frames drain what was snapped before the inputs moved
  task automatic snap(input logic [3:0] a, input logic [7:0] exp);
    int i;
    for (i = 0; i < 6; i++) next_frame;
    for (i = 0; i < 5 && got_addr != a; i++) next_frame;
    chk({got_addr, got_data}, {a, exp});
  endtask
  task give_verdict;
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_frame0;
    f0 = 7'h75;
    step(1);
    f0 = 7'h54;
    snap(4'h0, 8'hD5);
    f0 = 7'h0A;
    snap(4'h0, 8'h0B);
    f0 = 7'h40;
    snap(4'h0, 8'h81);
  endtask
  task automatic t_pulses;
    int i;
    int n;
    n = 0;
    ev[2:0] = 3'h7;
    step(1);
    ev[2:0] = 3'h0;
    for (i = 0; i < 14; i++) begin
      next_frame;
      if (got_addr == 4'h1 && got_data[7:5] != 3'h0) begin
        chk(got_data[7:5], 3'h7);
        n++;
      end
    end
    chk(n >= 1 && n <= 2, 1'b1);
  endtask
  // the code pins are scrambled after the strobe to prove the latch
  task automatic t_codes;
    int i;
    for (i = 0; i < 8; i++) begin
      tc = i[2:0];
      ev[3] = i[0];
      tv = 1'b1;
      step(1);
      tv = 1'b0;
      tc = ~tc;
      snap(4'h1, {3'h0, i[0], i[2:0], 1'b0});
    end
    ev[3] = 1'b0;
  endtask
  task automatic t_stores;
    st2 = 6'h3F;
    snap(4'h2, 8'hFC);
    st2 = 6'h1B;
    snap(4'h2, 8'h44);
    st3 = 3'h5;
    ch = 5'h17;
    tls = 5'h1F;
    snap(4'h3, 8'hB7);
    st3 = 3'h2;
    ch = 5'h00;
    snap(4'h3, 8'h40);
  endtask
  task automatic t_order;
    int i;
    logic [3:0] a;
    next_frame;
    a = got_addr;
    for (i = 0; i < 10; i++) begin
      next_frame;
      a = (a == 4'h4) ? 4'h0 : a + 4'h1;
      chk({got_bits, got_addr}, {5'h0C, a});
    end
  endtask
  // abort mid-frame, then run the mid and slow rates for a while
  task automatic t_rates;
    logic [15:0] c;
    next_frame;
    step(100);
    rate = 2'h0;
    step(2);
    c = frame_count;
    step(600);
    chk(frame_count, c);
    chk({status_clock, status_load, status_data}, 3'h0);
    rate = 2'h2;
    next_frame;
    next_frame;
    chk(got_bits, 5'h0C);
    rate = 2'h0;
    step(2);
    rate = 2'h1;
    step(3200);
    rate = 2'h0;
    step(2);
    rate = 2'h3;
    next_frame;
    next_frame;
    chk(got_bits, 5'h0C);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    step(4);
    reset_n = 1'b1;
    step(3); // inner reset lets go two edges after the pin
    t_frame0;
    t_pulses;
    t_codes;
    t_stores;
    t_order;
    t_rates;
    give_verdict;
  end

  // well over half beyond the expected run length of some 60000 cycles
  initial begin
    #950000;
    n_fail++;
    give_verdict;
  end
endmodule // smfs_top_test
